// *** core/standby_pkg.sv ***
// shared constants of the standby and clock-mode controller
`default_nettype none
package standby_pkg;
	// register byte offsets
	localparam logic [7:0] system_control_two_addr = 8'h00;
	localparam logic [7:0] timebase_control_addr = 8'h04;
	localparam logic [7:0] irq_control_addr = 8'h08;
	localparam logic [7:0] irq_enable_addr = 8'h0C;
	localparam logic [7:0] irq_pending_addr = 8'h10;
	localparam logic [7:0] status_addr = 8'h14;
	// system_control_two fields
	localparam int high_osc_bit = 7;
	localparam int low_osc_bit = 6;
	localparam int sysclk_sel_bit = 5;
	localparam int idle_req_bit = 4;
	localparam int tg_halt_bit = 2;
	localparam logic [7:0] system_control_two_rst = 8'h80;
	localparam logic [7:0] system_control_two_mask = 8'hF4;
	// timebase_control fields
	localparam int timebase_enable_bit = 3;
	localparam int tb_sel_lsb = 0;
	localparam int tb_sel_width = 3;
	localparam int tb_taps = 8;
	localparam logic [7:0] timebase_control_rst = 8'h00;
	// interrupt sources
	localparam int irq_count = 8;
	localparam int watchdog_irq_bit = 0;
	localparam int timebase_irq_bit = 7;
	localparam logic [7:0] irq_rst = 8'h00;
	// status fields
	localparam int status_mode_lsb = 0;
	localparam int status_pc_lsb = 16;
	// program counter offset past the halt-starting instruction
	localparam logic [15:0] halt_pc_step = 16'h0002;
	// controller states
	typedef enum logic [1:0] {
		st_run,
		st_light_halt,
		st_deep_halt
	} halt_state_t;
endpackage : standby_pkg
`default_nettype wire

// *** core/timebase_edge.sv ***
// selects a time base tap, synchronises it and flags its falling edge
`default_nettype none
module timebase_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [standby_pkg::tb_taps-1:0] tb_tap,
	input wire logic [standby_pkg::tb_sel_width-1:0] tb_select,
	output logic tb_fall
);
	import standby_pkg::*;

	logic [tb_taps-1:0] sync_a;
	logic [tb_taps-1:0] sync_b;
	logic tap_prev;
	logic next_tap_prev;
	logic next_fall;

	// two-stage synchroniser per tap; taps are async to pclk
	genvar gi;
	generate
		for (gi = 0; gi < tb_taps; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= tb_tap[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	// the edge is judged on the synchronised tap, so the wait can end early after a select change
	always_comb begin
		next_tap_prev = sync_b[tb_select];
		next_fall = tap_prev & ~sync_b[tb_select];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tap_prev <= 1'b0;
			tb_fall <= 1'b0;
		end else begin
			tap_prev <= next_tap_prev;
			tb_fall <= next_fall;
		end
	end

	a_fall_source: assert property (@(posedge pclk) disable iff (!presetn)
		tb_fall |-> $past(tap_prev) && !$past(sync_b[tb_select]))
		else $error("falling edge flagged without a falling tap");
endmodule : timebase_edge
`default_nettype wire

// *** core/standby_mode_controller.sv ***
// standby and clock-mode controller with an APB register slave
//
// Our own choices: the placing of the registers and register access over APB.
`default_nettype none
// Contract
// - light halt stops CPU and watchdog; peripherals keep clocks.
// - light halt keeps memory, registers, status word and port latches unchanged.
// - halt resume address is the requesting instruction address plus two.
// - firmware clears master enable, sets wake enable; idle bit write enters light halt.
// - master enable low: enabled interrupt ends light halt, no vectoring.
// - master enable high: enabled interrupt ends light halt and is serviced.
// - light halt end clears idle bit and returns to prior mode.
// - reset ends any halt; restart in fast single clock mode.
// - watchdog interrupt just before a halt request is serviced, halt refused.
// - deep halt stops every peripheral clock except the time base timer.
// - writing the timing generator halt bit to one enters deep halt.
// - AND of enables low: tap falling edge ends deep halt, no service.
// - AND of enables high: tap falling edge ends deep halt with service.
// - deep halt end clears halt bit and restores prior mode.
// - time base enabled at deep halt request sets the time base latch.
// - deep halt entry and exit ignore the time base enable.
// - asynchronous release may make the deep halt shorter than selected.
// - clearing both oscillator enables in one write raises a system clock reset.
module standby_mode_controller (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [standby_pkg::irq_count-1:0] irq_source,
	input wire logic [15:0] instr_addr,
	input wire logic [standby_pkg::tb_taps-1:0] tb_tap,
	output logic cpu_halt,
	output logic watchdog_halt,
	output logic periph_clk_stop,
	output logic high_osc_en,
	output logic low_osc_en,
	output logic sysclk_select,
	output logic sysclk_reset,
	output logic irq_service,
	output logic [2:0] irq_service_id,
	output logic resume_pulse,
	output logic [15:0] halt_pc
);
	import standby_pkg::*;

	halt_state_t state, next_state;
	logic [7:0] sysctl, next_sysctl;
	logic [7:0] tbctl, next_tbctl;
	logic master_en, next_master_en;
	logic [7:0] irq_en, next_irq_en;
	logic [7:0] irq_pend, next_irq_pend;
	logic [15:0] next_halt_pc;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic next_sysclk_reset, next_irq_service, next_resume_pulse;
	logic [2:0] next_irq_service_id;
	logic tb_fall;
	logic wr_take, setup;
	logic idle_req, deep_req, wd_block;
	logic [7:0] wake;
	logic tb_and;

	// lowest-numbered pending source wins service
	function automatic logic [2:0] first_set(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = irq_count - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : first_set

	// address decode for the error answer; the read mux has its own case decode
	function automatic logic mapped(input logic [7:0] a);
		return a == system_control_two_addr || a == timebase_control_addr ||
			a == irq_control_addr || a == irq_enable_addr ||
			a == irq_pending_addr || a == status_addr;
	endfunction : mapped

	timebase_edge u_tb_edge (
		.pclk(pclk),
		.presetn(presetn),
		.tb_tap(tb_tap),
		.tb_select(tbctl[tb_sel_lsb +: tb_sel_width]),
		.tb_fall(tb_fall)
	);

	// bus phase qualifiers; a write lands only at the access edge with pready high
	assign setup = psel & ~penable;
	assign wr_take = psel & penable & pready & pwrite;
	assign idle_req = wr_take && paddr == system_control_two_addr && pwdata[idle_req_bit];
	assign deep_req = wr_take && paddr == system_control_two_addr && pwdata[tg_halt_bit];
	// a watchdog event just ahead of the request cancels it
	assign wd_block = irq_pend[watchdog_irq_bit] | irq_source[watchdog_irq_bit];
	assign wake = irq_pend & irq_en;
	assign tb_and = master_en & irq_en[timebase_irq_bit] & tbctl[timebase_enable_bit];

	// register file and halt sequencing
	always_comb begin
		next_state = state;
		next_sysctl = sysctl;
		next_tbctl = tbctl;
		next_master_en = master_en;
		next_irq_en = irq_en;
		next_halt_pc = halt_pc;
		next_sysclk_reset = 1'b0;
		next_irq_service = 1'b0;
		next_irq_service_id = irq_service_id;
		next_resume_pulse = 1'b0;
		// software clear first so that a new event below wins over it
		next_irq_pend = irq_pend;
		if (wr_take && paddr == irq_pending_addr) begin
			next_irq_pend = irq_pend & ~pwdata[7:0];
		end
		next_irq_pend = next_irq_pend | irq_source;
		if (tb_fall && tbctl[timebase_enable_bit]) begin
			next_irq_pend[timebase_irq_bit] = 1'b1;
		end
		if (wr_take && state == st_run) begin
			case (paddr)
				system_control_two_addr: begin
					next_sysctl = pwdata[7:0] & system_control_two_mask;
					// both oscillators off would leave the CPU with no clock
					if (!pwdata[high_osc_bit] && !pwdata[low_osc_bit]) begin
						next_sysctl = system_control_two_rst;
						next_sysclk_reset = 1'b1;
					end
				end
				timebase_control_addr: next_tbctl = pwdata[7:0] & 8'h0F;
				irq_control_addr: next_master_en = pwdata[0];
				irq_enable_addr: next_irq_en = pwdata[7:0];
				default: ;
			endcase
		end
		case (state)
			st_run: begin
				if ((idle_req || deep_req) && !next_sysclk_reset) begin
					if (wd_block) begin
						// service the watchdog, stay running
						next_sysctl[idle_req_bit] = 1'b0;
						next_sysctl[tg_halt_bit] = 1'b0;
						next_irq_service = 1'b1;
						next_irq_service_id = 3'(watchdog_irq_bit);
					end else begin
						next_halt_pc = 16'(instr_addr + halt_pc_step);
						if (deep_req) begin
							next_state = st_deep_halt;
							next_sysctl[idle_req_bit] = 1'b0;
							if (tbctl[timebase_enable_bit]) begin
								next_irq_pend[timebase_irq_bit] = 1'b1;
							end
						end else begin
							next_state = st_light_halt;
						end
					end
				end
			end
			st_light_halt: begin
				if (wake != 8'h00) begin
					next_state = st_run;
					next_sysctl[idle_req_bit] = 1'b0;
					if (master_en) begin
						next_irq_service = 1'b1;
						next_irq_service_id = first_set(wake);
					end else begin
						next_resume_pulse = 1'b1;
					end
				end
			end
			st_deep_halt: begin
				// release ignores the time base enable; only service depends on it
				if (tb_fall) begin
					next_state = st_run;
					next_sysctl[tg_halt_bit] = 1'b0;
					if (tb_and) begin
						next_irq_service = 1'b1;
						next_irq_service_id = 3'(timebase_irq_bit);
					end else begin
						next_resume_pulse = 1'b1;
					end
				end
			end
			default: next_state = st_run;
		endcase
	end

	// read data and answer prepared in the setup cycle, shown in the access cycle
	always_comb begin
		next_pready = setup;
		next_pslverr = setup & ~mapped(paddr);
		next_prdata = 32'h0000_0000;
		if (setup && !pwrite) begin
			case (paddr)
				system_control_two_addr: next_prdata = {24'h00_0000, sysctl};
				timebase_control_addr: next_prdata = {24'h00_0000, tbctl};
				irq_control_addr: next_prdata = {31'h0000_0000, master_en};
				irq_enable_addr: next_prdata = {24'h00_0000, irq_en};
				irq_pending_addr: next_prdata = {24'h00_0000, irq_pend};
				status_addr: next_prdata = {halt_pc, 14'h0000, state};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// reset lands in fast single clock mode with all halts ended
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_run;
			sysctl <= system_control_two_rst;
			tbctl <= timebase_control_rst;
			master_en <= 1'b0;
			irq_en <= irq_rst;
			irq_pend <= irq_rst;
			halt_pc <= 16'h0000;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			sysclk_reset <= 1'b0;
			irq_service <= 1'b0;
			irq_service_id <= 3'h0;
			resume_pulse <= 1'b0;
			cpu_halt <= 1'b0;
			watchdog_halt <= 1'b0;
			periph_clk_stop <= 1'b0;
			high_osc_en <= 1'b1;
			low_osc_en <= 1'b0;
			sysclk_select <= 1'b0;
		end else begin
			state <= next_state;
			sysctl <= next_sysctl;
			tbctl <= next_tbctl;
			master_en <= next_master_en;
			irq_en <= next_irq_en;
			irq_pend <= next_irq_pend;
			halt_pc <= next_halt_pc;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			sysclk_reset <= next_sysclk_reset;
			irq_service <= next_irq_service;
			irq_service_id <= next_irq_service_id;
			resume_pulse <= next_resume_pulse;
			// CPU core holds its own state while stalled, so nothing else is touched
			cpu_halt <= next_state != st_run;
			watchdog_halt <= next_state != st_run;
			periph_clk_stop <= next_state == st_deep_halt;
			// oscillator bits stay as set, so leaving a halt restores the prior mode
			high_osc_en <= next_sysctl[high_osc_bit];
			low_osc_en <= next_sysctl[low_osc_bit];
			sysclk_select <= next_sysctl[sysclk_sel_bit];
		end
	end

	a_light_entry: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_run && idle_req && !deep_req && !wd_block && !next_sysclk_reset)
		|=> state == st_light_halt && cpu_halt && watchdog_halt && !periph_clk_stop)
		else $error("idle request did not enter light halt");
	a_light_clocks: assert property (@(posedge pclk) disable iff (!presetn)
		state == st_light_halt |-> cpu_halt && watchdog_halt && !periph_clk_stop)
		else $error("light halt clock gating wrong");
	a_resume_pc: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_run && next_state != st_run) |=> halt_pc == 16'($past(instr_addr) + 16'h0002))
		else $error("resume address not two past the instruction");
	a_quiet_release: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_light_halt && wake != 8'h00 && !master_en)
		|=> resume_pulse && !irq_service && state == st_run && !sysctl[idle_req_bit])
		else $error("light halt release without master enable wrong");
	a_vector_release: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_light_halt && wake != 8'h00 && master_en)
		|=> irq_service && !resume_pulse && state == st_run)
		else $error("light halt release did not request service");
	a_wd_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_run && (idle_req || deep_req) && wd_block && !next_sysclk_reset)
		|=> state == st_run && irq_service && irq_service_id == 3'h0)
		else $error("halt entered despite watchdog event");
	a_deep_entry: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_run && deep_req && !wd_block && !next_sysclk_reset)
		|=> state == st_deep_halt && periph_clk_stop && sysctl[tg_halt_bit])
		else $error("halt bit write did not enter deep halt");
	a_tb_latch: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_run && deep_req && !wd_block && !next_sysclk_reset &&
		tbctl[timebase_enable_bit]) |=> irq_pend[timebase_irq_bit])
		else $error("time base latch not set at deep halt request");
	a_deep_exit: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_deep_halt && tb_fall)
		|=> state == st_run && !sysctl[tg_halt_bit] && (irq_service ^ resume_pulse))
		else $error("deep halt exit wrong");
	a_deep_service: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_deep_halt && tb_fall) |=> irq_service == $past(tb_and))
		else $error("deep halt service choice wrong");
	a_clock_reset: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_take && state == st_run && paddr == system_control_two_addr &&
		!pwdata[high_osc_bit] && !pwdata[low_osc_bit])
		|=> sysclk_reset && high_osc_en && !low_osc_en ##1 !sysclk_reset)
		else $error("system clock reset not raised");
endmodule : standby_mode_controller
`default_nettype wire

// *** sim/standby_mode_controller_tb.sv ***
// self-checking testbench of the standby and clock-mode controller
`default_nettype none
module standby_mode_controller_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import standby_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [irq_count-1:0] irq_source;
	logic [tb_taps-1:0] tb_tap;
	logic [15:0] instr_addr, halt_pc;
	logic cpu_halt, watchdog_halt, periph_clk_stop, high_osc_en, low_osc_en;
	logic sysclk_select, sysclk_reset, irq_service, resume_pulse, err;
	logic [2:0] irq_service_id, svc_id;
	int fail_count, comparisons, cycles, svc_n, res_n, srst_n, s0, r0, q0;

	standby_mode_controller i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_source(irq_source),
		.instr_addr(instr_addr), .tb_tap(tb_tap), .cpu_halt(cpu_halt),
		.watchdog_halt(watchdog_halt), .periph_clk_stop(periph_clk_stop),
		.high_osc_en(high_osc_en), .low_osc_en(low_osc_en), .sysclk_select(sysclk_select),
		.sysclk_reset(sysclk_reset), .irq_service(irq_service),
		.irq_service_id(irq_service_id), .resume_pulse(resume_pulse), .halt_pc(halt_pc));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// one-cycle pulses are counted here so no scenario can miss them
	always @(posedge pclk) begin
		cycles++;
		if (irq_service === 1'b1) begin
			svc_n++;
			svc_id = irq_service_id;
		end
		if (resume_pulse === 1'b1) res_n++;
		if (sysclk_reset === 1'b1) srst_n++;
		if (cycles >= 20000) begin
			fail_count++;
			test_done();
		end
	end

	task test_done;
		if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// apb master: request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(rdat, e);
	endtask : rd

	// let n edges land, then look at settled outputs
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick

	task pulse_irq(input int k);
		@(posedge pclk);
		irq_source <= 8'h01 << k;
		@(posedge pclk);
		irq_source <= 8'h00;
	endtask : pulse_irq

	task mark;
		s0 = svc_n;
		r0 = res_n;
	endtask : mark

	// bounded wait for a service or resume pulse
	task wait_evt;
		for (int i = 0; i < 40 && svc_n == s0 && res_n == r0; i++) @(posedge pclk);
		tick(1);
	endtask : wait_evt

	task t_light(input logic men, input int k);
		logic [15:0] pc;
		pc = 16'h1236 + 16'(k);
		wr(irq_control_addr, {31'h0, men});
		wr(irq_enable_addr, 32'h1 << k);
		@(posedge pclk);
		instr_addr <= 16'h1234 + 16'(k);
		wr(system_control_two_addr, 32'h90);
		tick(1);
		check(cpu_halt, 1);
		check(watchdog_halt, 1);
		check(periph_clk_stop, 0);
		check(halt_pc, pc);
		rd(status_addr, {pc, 16'h0001});
		// a write while halted must be ignored
		wr(irq_control_addr, {31'h0, !men});
		mark();
		pulse_irq(k);
		wait_evt();
		check(cpu_halt, 0);
		check(svc_n - s0, men);
		check(res_n - r0, !men);
		if (men) check(svc_id, k);
		rd(system_control_two_addr, 32'h80);
		rd(irq_control_addr, {31'h0, men});
		wr(irq_pending_addr, 32'h1 << k);
		rd(irq_pending_addr, 32'h0);
	endtask : t_light

	task t_refuse;
		mark();
		pulse_irq(watchdog_irq_bit);
		wr(system_control_two_addr, 32'h90);
		tick(1);
		check(cpu_halt, 0);
		check(svc_n - s0, 1);
		check(svc_id, 0);
		rd(system_control_two_addr, 32'h80);
		wr(irq_pending_addr, 32'h1);
	endtask : t_refuse

	task t_deep(input logic men, input logic tben, input int s);
		wr(irq_control_addr, {31'h0, men});
		wr(irq_enable_addr, 32'h80);
		wr(timebase_control_addr, {28'h0, tben, 3'(s)});
		// peripheral events held quiet before the deep request
		irq_source <= 8'h00;
		wr(system_control_two_addr, 32'h84);
		tick(1);
		check(periph_clk_stop, 1);
		check(cpu_halt, 1);
		rd(irq_pending_addr, {24'h0, tben, 7'h0});
		mark();
		@(posedge pclk);
		tb_tap[s] <= 1'b0;
		wait_evt();
		check(periph_clk_stop, 0);
		check(svc_n - s0, men & tben);
		check(res_n - r0, !(men & tben));
		if (men & tben) check(svc_id, timebase_irq_bit);
		rd(system_control_two_addr, 32'h80);
		@(posedge pclk);
		tb_tap[s] <= 1'b1;
		wr(irq_pending_addr, 32'h80);
	endtask : t_deep

	task t_osc;
		// low oscillator first, warm-up wait, then switch with the fast one still running
		wr(system_control_two_addr, 32'hC0);
		tick(1);
		check({high_osc_en, low_osc_en, sysclk_select}, 3'b110);
		tick(16);
		wr(system_control_two_addr, 32'hE0);
		tick(1);
		check({high_osc_en, low_osc_en, sysclk_select}, 3'b111);
		wr(system_control_two_addr, 32'h60);
		tick(1);
		check({high_osc_en, low_osc_en, sysclk_select}, 3'b011);
		q0 = srst_n;
		wr(system_control_two_addr, 32'h00);
		tick(2);
		check(srst_n - q0, 1);
		rd(system_control_two_addr, 32'h80);
		apb(1'b0, 8'h20, 32'h0);
		check(err, 1);
	endtask : t_osc

	task t_reset_halt;
		wr(system_control_two_addr, 32'h90);
		tick(1);
		check(cpu_halt, 1);
		@(posedge pclk);
		presetn <= 1'b0;
		tick(2);
		check(cpu_halt, 0);
		check(high_osc_en, 1);
		@(posedge pclk);
		presetn <= 1'b1;
		rd(system_control_two_addr, 32'h80);
		rd(status_addr, 32'h0);
	endtask : t_reset_halt

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		irq_source = 8'h00;
		tb_tap = 8'hFF;
		instr_addr = 16'h0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(system_control_two_addr, 32'h80);
		t_light(1'b0, 3);
		t_light(1'b1, 5);
		t_refuse();
		t_deep(1'b0, 1'b1, 0);
		t_deep(1'b1, 1'b1, 3);
		t_deep(1'b1, 1'b0, 6);
		t_osc();
		t_reset_halt();
		test_done();
	end
endmodule : standby_mode_controller_tb
`default_nettype wire
